// ---- bench/ldfc_checker.sv ----
// Port-level assertions for the dimming and fail-safe configuration slice.
module ldfc_checker
    import ldfc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    input wire logic [7:0] rd_data,
    input wire logic exponential_curve_enable,
    input wire logic phase_shift_enable,
    input wire logic high_resolution_enable,
    input wire logic power_save_enable,
    input wire logic [3:0] pwm_frequency_select,
    input wire logic [14:0] pwm_freq_hz,
    input wire logic [2:0] safe_map_group_a,
    input wire logic [2:0] safe_map_group_b,
    input wire logic [2:0] safe_map_group_c,
    input wire logic [2:0] safe_map_group_d,
    input wire logic config_ready
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    logic [7:0] dim_out;
    assign dim_out = {exponential_curve_enable, phase_shift_enable, high_resolution_enable,
        power_save_enable, pwm_frequency_select};
    a_rsvd_reads_zero: assert property ($past(rd_strobe) && $past(addr) == OFF_DIM_RSVD
        |-> rd_data == 8'h00) else $error("reserved byte read not zero");
    a_ab_gaps_zero: assert property ($past(rd_strobe) && $past(addr) == OFF_MAP_AB
        |-> (rd_data & 8'h88) == 8'h00) else $error("map AB reserved bits set");
    a_cd_gaps_zero: assert property ($past(rd_strobe) && $past(addr) == OFF_MAP_CD
        |-> (rd_data & 8'h88) == 8'h00) else $error("map CD reserved bits set");
    a_dim_write_fields: assert property (wr_strobe && addr == OFF_DIM_CTRL && config_ready
        |-> ##2 dim_out == $past(wr_data, 2)) else $error("dimming outputs wrong");
    a_ab_write_groups: assert property (wr_strobe && addr == OFF_MAP_AB && config_ready
        |-> ##2 {safe_map_group_b, safe_map_group_a} == {$past(wr_data[6:4], 2),
        $past(wr_data[2:0], 2)}) else $error("group A or B map wrong");
    a_cd_write_groups: assert property (wr_strobe && addr == OFF_MAP_CD && config_ready
        |-> ##2 {safe_map_group_d, safe_map_group_c} == {$past(wr_data[6:4], 2),
        $past(wr_data[2:0], 2)}) else $error("group C or D map wrong");
    a_freq_code_a: assert property (config_ready && pwm_frequency_select == 4'hA
        |-> pwm_freq_hz == 15'h190) else $error("code A frequency wrong");
    a_freq_code_top: assert property (config_ready && pwm_frequency_select == 4'hF
        |-> pwm_freq_hz == 15'h5140) else $error("code F frequency wrong");
    a_reload_bound: assert property ($fell(reset) |-> ##[1:12] config_ready)
        else $error("reload did not finish");
endmodule

bind ldfc_top ldfc_checker u_chk (.clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
    .exponential_curve_enable(exponential_curve_enable), .phase_shift_enable(phase_shift_enable),
    .high_resolution_enable(high_resolution_enable), .power_save_enable(power_save_enable),
    .pwm_frequency_select(pwm_frequency_select), .pwm_freq_hz(pwm_freq_hz),
    .safe_map_group_a(safe_map_group_a), .safe_map_group_b(safe_map_group_b),
    .safe_map_group_c(safe_map_group_c), .safe_map_group_d(safe_map_group_d),
    .config_ready(config_ready));

// ---- bench/led_dimming_failsafe_config_tb_top.sv ----
// Self-checking bench for the dimming and fail-safe configuration slice.
module led_dimming_failsafe_config_tb_top import ldfc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, reset = 1'b1, wr_strobe = 1'b0, rd_strobe = 1'b0, nvm_wr_en = 1'b0;
    logic [7:0] addr = 8'h00, wr_data = 8'h00, nvm_wr_data = 8'h00, rd_data;
    logic [1:0] nvm_wr_index = 2'h0;
    logic ex, ph, hr, ps, tick, config_ready;
    logic [3:0] fs;
    logic [14:0] hz;
    logic [2:0] ga, gb, gc, gd;
    logic [14:0] tbl [16] = '{15'h0C8, 15'h0FA, 15'h12C, 15'h15E, 15'h190, 15'h1F4, 15'h258,
        15'h320, 15'h3E8, 15'h4B0, 15'h190, 15'h190, 15'h170C, 15'h1E78, 15'h2580, 15'h5140};
    int failures = 0, comparisons = 0;
    ldfc_top #(.NVM_DIM(8'hCA), .NVM_AB(8'hB6), .NVM_CD(8'h1D)) dut (.clk(clk),
        .reset(reset), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe), .rd_data(rd_data), .nvm_wr_en(nvm_wr_en),
        .nvm_wr_index(nvm_wr_index), .nvm_wr_data(nvm_wr_data), .exponential_curve_enable(ex),
        .phase_shift_enable(ph), .high_resolution_enable(hr), .power_save_enable(ps),
        .pwm_frequency_select(fs), .pwm_freq_hz(hz), .pwm_period_tick(tick),
        .safe_map_group_a(ga), .safe_map_group_b(gb), .safe_map_group_c(gc),
        .safe_map_group_d(gd), .config_ready(config_ready));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic conclude();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_strobe <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_strobe <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd_strobe <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_strobe <= 1'b0;
        #1;
        chk({8'h00, rd_data}, {8'h00, exp}, "read data");
    endtask
    task automatic pulse_reset();
        @(posedge clk);
        reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (config_ready !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (config_ready !== 1'b1) begin
            failures++;
            $display("BAD %0t reload never finished", $time);
            conclude();
        end
    endtask
    task automatic t_reload();
        rd(OFF_DIM_CTRL, 8'hCA);
        rd(OFF_MAP_AB, 8'h36);
        rd(OFF_MAP_CD, 8'h15);
        chk({4'h0, ga, gb, gc, gd}, {4'h0, 3'h6, 3'h3, 3'h5, 3'h1}, "reloaded groups");
        chk({1'b0, hz}, {1'b0, tbl[10]}, "reloaded frequency");
    endtask
    task automatic t_dim_codes();
        for (int c = 0; c < 16; c++) begin
            wr(OFF_DIM_CTRL, {~c[3:0], c[3:0]});
            @(posedge clk);
            #1;
            chk({8'h00, ex, ph, hr, ps, fs}, {8'h00, ~c[3:0], c[3:0]}, "dimming fields");
            chk({1'b0, hz}, {1'b0, tbl[c]}, "frequency");
        end
        rd(OFF_DIM_CTRL, 8'h0F);
    endtask
    // Measures the cycles between two period ticks at the highest rate code.
    task automatic t_tick();
        int n;
        n = 0;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(posedge clk);
                #1;
                n++;
            end while (tick !== 1'b1 && n < 3000);
        end
        chk(16'(n), 16'(CLK_HZ / 20800), "tick period");
        if (n >= 3000) begin
            conclude();
        end
    endtask
    task automatic t_maps();
        wr(OFF_MAP_AB, 8'hFF);
        wr(OFF_MAP_CD, 8'h10);
        @(posedge clk);
        #1;
        chk({4'h0, ga, gb, gc, gd}, {4'h0, 3'h7, 3'h7, 3'h0, 3'h1}, "written groups");
        rd(OFF_MAP_AB, 8'h77);
        rd(OFF_MAP_CD, 8'h10);
    endtask
    task automatic t_reserved();
        wr(OFF_DIM_RSVD, 8'hFF);
        wr(8'h55, 8'hAA);
        rd(OFF_DIM_RSVD, 8'h00);
        rd(8'h55, 8'h00);
        rd(OFF_NVM_STATUS, 8'h01);
        rd(OFF_MAP_AB, 8'h77);
    endtask
    task automatic t_nvm();
        @(posedge clk);
        nvm_wr_en <= 1'b1;
        nvm_wr_data <= 8'h3C;
        @(posedge clk);
        nvm_wr_index <= 2'h2;
        nvm_wr_data <= 8'hFF;
        @(posedge clk);
        nvm_wr_en <= 1'b0;
        pulse_reset();
        wr(OFF_DIM_CTRL, 8'hFF);
        wait_ready();
        rd(OFF_DIM_CTRL, 8'h3C);
        rd(OFF_MAP_CD, 8'h77);
        chk({1'b0, hz}, {1'b0, tbl[12]}, "frequency after reload");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        wait_ready();
        t_reload();
        t_dim_codes();
        t_tick();
        t_maps();
        t_reserved();
        t_nvm();
        conclude();
    end
endmodule

// ---- logic/ldfc_decode.sv ----
// Decodes the frequency code of the dimming control byte into the PWM rate in Hz and the PWM period enable.
module ldfc_decode
    import ldfc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] dim_byte,
    output logic [14:0] pwm_freq_hz,
    output logic pwm_period_tick
);
    logic [19:0] period_cycles;
    logic [19:0] count_reg;

    // Code Ah falls back to the same rate as code Bh.
    always_ff @(posedge clk) begin
        if (reset) begin
            pwm_freq_hz <= 15'd0;
        end else begin
            pwm_freq_hz <= pwm_hz(dim_byte[FREQ_MSB:FREQ_LSB]);
        end
    end

    assign period_cycles = (pwm_freq_hz == 15'd0) ? 20'hFFFFF :
        20'(CLK_HZ / int'(pwm_freq_hz));

    always_ff @(posedge clk) begin
        if (reset || pwm_period_tick) begin
            count_reg <= 20'h00000;
        end else begin
            count_reg <= count_reg + 20'h00001;
        end
    end

    assign pwm_period_tick = (count_reg + 20'h00001 >= period_cycles);
endmodule

// ---- logic/ldfc_nvm.sv ----
// Small non-volatile copy store: register-read memory with a write port.
module ldfc_nvm
    import ldfc_pkg::*;
#(
    parameter int WORDS = NVM_WORDS,
    parameter logic [7:0] INIT_DIM = 8'h00,
    parameter logic [7:0] INIT_AB = 8'h00,
    parameter logic [7:0] INIT_CD = 8'h00
) (
    input wire logic clk,
    input wire logic [1:0] rd_index,
    output logic [7:0] rd_data,
    input wire logic wr_en,
    input wire logic [1:0] wr_index,
    input wire logic [7:0] wr_data
);
    logic [7:0] mem_reg [WORDS];

    initial begin
        mem_reg[0] = INIT_DIM;
        mem_reg[1] = INIT_AB;
        mem_reg[2] = INIT_CD;
    end

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_reg[wr_index] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        rd_data <= mem_reg[rd_index];
    end
endmodule

// ---- logic/ldfc_pkg.sv ----
// Package with offsets, field layouts, write masks, copy indices, the clock rate and the PWM rate table of the configuration slice.
package ldfc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] OFF_DIM_CTRL = 8'h7E;
    localparam logic [7:0] OFF_DIM_RSVD = 8'h7F;
    localparam logic [7:0] OFF_MAP_AB = 8'h80;
    localparam logic [7:0] OFF_MAP_CD = 8'h81;
    localparam logic [7:0] OFF_NVM_STATUS = 8'hF0;
    localparam int BIT_EXP = 7;
    localparam int BIT_PHASE = 6;
    localparam int BIT_HIRES = 5;
    localparam int BIT_PSAVE = 4;
    localparam int FREQ_MSB = 3;
    localparam int FREQ_LSB = 0;
    localparam int MAP_LO_LSB = 0;
    localparam int MAP_HI_LSB = 4;
    localparam logic [7:0] MAP_WR_MASK = 8'h77;
    localparam logic [7:0] DIM_WR_MASK = 8'hFF;
    localparam logic [7:0] RSVD_VALUE = 8'h00;
    localparam logic [7:0] NVM_IDX_DIM = 8'h00;
    localparam logic [7:0] NVM_IDX_MAP_AB = 8'h01;
    localparam logic [7:0] NVM_IDX_MAP_CD = 8'h02;
    localparam int NVM_WORDS = 3;
    localparam int CLK_HZ = 25000000;
    localparam int FREQ_W = 15;
    localparam logic [3:0] FREQ_CODE_RSVD = 4'hA;
    localparam logic [14:0] FREQ_RSVD_HZ = 15'd400;

    typedef enum logic [3:0] {
        LDFC_IDLE = 4'b0001,
        LDFC_FETCH = 4'b0010,
        LDFC_STORE = 4'b0100,
        LDFC_READY = 4'b1000
    } ldfc_load_state_t;

    function automatic logic [14:0] pwm_hz(input logic [3:0] code);
        case (code)
            4'h0: pwm_hz = 15'd200;
            4'h1: pwm_hz = 15'd250;
            4'h2: pwm_hz = 15'd300;
            4'h3: pwm_hz = 15'd350;
            4'h4: pwm_hz = 15'd400;
            4'h5: pwm_hz = 15'd500;
            4'h6: pwm_hz = 15'd600;
            4'h7: pwm_hz = 15'd800;
            4'h8: pwm_hz = 15'd1000;
            4'h9: pwm_hz = 15'd1200;
            4'hB: pwm_hz = 15'd400;
            4'hC: pwm_hz = 15'd5900;
            4'hD: pwm_hz = 15'd7800;
            4'hE: pwm_hz = 15'd9600;
            4'hF: pwm_hz = 15'd20800;
            default: pwm_hz = FREQ_RSVD_HZ;
        endcase
    endfunction
endpackage

// ---- logic/ldfc_top.sv ----
// Dimming and fail-safe mapping configuration registers with non-volatile reload.
module ldfc_top
    import ldfc_pkg::*;
#(
    parameter logic [7:0] NVM_DIM = 8'h00,
    parameter logic [7:0] NVM_AB = 8'h00,
    parameter logic [7:0] NVM_CD = 8'h00
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [ldfc_pkg::ADDR_W-1:0] addr,
    input wire logic [ldfc_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [ldfc_pkg::DATA_W-1:0] rd_data,
    input wire logic nvm_wr_en,
    input wire logic [1:0] nvm_wr_index,
    input wire logic [7:0] nvm_wr_data,
    output logic exponential_curve_enable,
    output logic phase_shift_enable,
    output logic high_resolution_enable,
    output logic power_save_enable,
    output logic [3:0] pwm_frequency_select,
    output logic [14:0] pwm_freq_hz,
    output logic pwm_period_tick,
    output logic [2:0] safe_map_group_a,
    output logic [2:0] safe_map_group_b,
    output logic [2:0] safe_map_group_c,
    output logic [2:0] safe_map_group_d,
    output logic config_ready
);
    import ldfc_pkg::*;

    ldfc_load_state_t state_reg;
    ldfc_load_state_t state_next;
    logic [1:0] load_index_reg;
    logic [7:0] nvm_rd_data;
    logic [7:0] dim_reg;
    logic [7:0] map_ab_reg;
    logic [7:0] map_cd_reg;
    logic loading;

    ldfc_nvm #(
        .WORDS(NVM_WORDS),
        .INIT_DIM(NVM_DIM),
        .INIT_AB(NVM_AB),
        .INIT_CD(NVM_CD)
    ) u_nvm (
        .clk(clk),
        .rd_index(load_index_reg),
        .rd_data(nvm_rd_data),
        .wr_en(nvm_wr_en),
        .wr_index(nvm_wr_index),
        .wr_data(nvm_wr_data)
    );

    // Loader walks the three copies after every reset before software may write.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            LDFC_IDLE: state_next = LDFC_FETCH;
            LDFC_FETCH: state_next = LDFC_STORE;
            LDFC_STORE: begin
                if (load_index_reg == 2'(NVM_WORDS - 1)) begin
                    state_next = LDFC_READY;
                end else begin
                    state_next = LDFC_FETCH;
                end
            end
            LDFC_READY: state_next = LDFC_READY;
            default: state_next = LDFC_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= LDFC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            load_index_reg <= 2'b00;
        end else if (state_reg == LDFC_STORE && state_next == LDFC_FETCH) begin
            load_index_reg <= load_index_reg + 2'b01;
        end
    end

    assign loading = (state_reg != LDFC_READY);
    assign config_ready = !loading;

    // Reload from the non-volatile copies; software writes are ignored until loading ends.
    always_ff @(posedge clk) begin
        if (reset) begin
            dim_reg <= 8'h00;
        end else if (state_reg == LDFC_STORE && load_index_reg == NVM_IDX_DIM[1:0]) begin
            dim_reg <= nvm_rd_data & DIM_WR_MASK;
        end else if (!loading && wr_strobe && addr == OFF_DIM_CTRL) begin
            dim_reg <= wr_data & DIM_WR_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            map_ab_reg <= 8'h00;
        end else if (state_reg == LDFC_STORE && load_index_reg == NVM_IDX_MAP_AB[1:0]) begin
            map_ab_reg <= nvm_rd_data & MAP_WR_MASK;
        end else if (!loading && wr_strobe && addr == OFF_MAP_AB) begin
            map_ab_reg <= wr_data & MAP_WR_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            map_cd_reg <= 8'h00;
        end else if (state_reg == LDFC_STORE && load_index_reg == NVM_IDX_MAP_CD[1:0]) begin
            map_cd_reg <= nvm_rd_data & MAP_WR_MASK;
        end else if (!loading && wr_strobe && addr == OFF_MAP_CD) begin
            map_cd_reg <= wr_data & MAP_WR_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rd_data <= 8'h00;
        end else if (rd_strobe) begin
            case (addr)
                OFF_DIM_CTRL: rd_data <= dim_reg;
                OFF_DIM_RSVD: rd_data <= RSVD_VALUE;
                OFF_MAP_AB: rd_data <= map_ab_reg;
                OFF_MAP_CD: rd_data <= map_cd_reg;
                OFF_NVM_STATUS: rd_data <= {7'h00, config_ready};
                default: rd_data <= 8'h00;
            endcase
        end else begin
            rd_data <= 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            exponential_curve_enable <= 1'b0;
            phase_shift_enable <= 1'b0;
            high_resolution_enable <= 1'b0;
            power_save_enable <= 1'b0;
            pwm_frequency_select <= 4'h0;
        end else begin
            exponential_curve_enable <= dim_reg[BIT_EXP];
            phase_shift_enable <= dim_reg[BIT_PHASE];
            high_resolution_enable <= dim_reg[BIT_HIRES];
            power_save_enable <= dim_reg[BIT_PSAVE];
            pwm_frequency_select <= dim_reg[FREQ_MSB:FREQ_LSB];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            safe_map_group_a <= 3'h0;
            safe_map_group_b <= 3'h0;
            safe_map_group_c <= 3'h0;
            safe_map_group_d <= 3'h0;
        end else begin
            safe_map_group_a <= map_ab_reg[MAP_LO_LSB +: 3];
            safe_map_group_b <= map_ab_reg[MAP_HI_LSB +: 3];
            safe_map_group_c <= map_cd_reg[MAP_LO_LSB +: 3];
            safe_map_group_d <= map_cd_reg[MAP_HI_LSB +: 3];
        end
    end

    ldfc_decode u_decode (
        .clk(clk),
        .reset(reset),
        .dim_byte(dim_reg),
        .pwm_freq_hz(pwm_freq_hz),
        .pwm_period_tick(pwm_period_tick)
    );
endmodule
